// ---- accel_cfg_pkg.sv ----
package accel_cfg_pkg;

  localparam int AXW     = 14;
  localparam int RAWW    = 16;
  localparam int NAX     = 3;
  localparam int KW      = 4;
  localparam int RANGE_W = 2;
  localparam int SEL_W   = 2;
  localparam int RATES   = 8;

  // Register map
  localparam logic [7:0] ADDR_DATA_CFG = 8'h0e;
  localparam logic [7:0] ADDR_HPF_CUT  = 8'h0f;
  localparam int HPF_OUT_BIT   = 4;
  localparam int RANGE_LSB     = 0;
  localparam int PULSE_BYP_BIT = 5;
  localparam int PULSE_LPF_BIT = 4;
  localparam int SEL_LSB       = 0;

  typedef logic signed [AXW-1:0]  axis_t;
  typedef logic signed [RAWW-1:0] raw_t;
  typedef logic signed [RAWW:0]   wide_t;
  typedef struct packed { axis_t [NAX-1:0] ax; } sample_t;
  typedef struct packed { raw_t [NAX-1:0] ax; }  raw_sample_t;

  typedef enum logic [1:0] {
    RANGE_2G   = 2'b00,
    RANGE_4G   = 2'b01,
    RANGE_8G   = 2'b10,
    RANGE_RSVD = 2'b11
  } range_t;

  typedef enum logic [1:0] {
    OS_NORMAL                = 2'b00,
    LOW_POWER_LOW_NOISE_MODE = 2'b01,
    OS_HIGH_RES              = 2'b10,
    OS_LOW_POWER             = 2'b11
  } os_mode_t;

  typedef enum logic [2:0] {
    RATE_800  = 3'b000,
    RATE_400  = 3'b001,
    RATE_200  = 3'b010,
    RATE_100  = 3'b011,
    RATE_50   = 3'b100,
    RATE_12P5 = 3'b101,
    RATE_6P25 = 3'b110,
    RATE_1P56 = 3'b111
  } rate_t;

  typedef struct packed {
    logic   hpf_out;
    range_t range_select;
  } data_cfg_t;

  typedef struct packed {
    logic             pulse_hpf_byp;
    logic             pulse_lpf_en;
    logic [SEL_W-1:0] cutoff_sel;
  } cut_cfg_t;

  localparam data_cfg_t DATA_CFG_RST = '{1'b0, RANGE_2G};
  localparam cut_cfg_t  HPF_CUT_RST  = '{1'b0, 1'b0, 2'h0};

  // Sensitivity in micro-g per LSB
  localparam logic [9:0] SENS_2G_UG = 10'h0f4;
  localparam logic [9:0] SENS_4G_UG = 10'h1e8;
  localparam logic [9:0] SENS_8G_UG = 10'h3d0;
  localparam int SHIFT_4G = 1;
  localparam int SHIFT_8G = 2;

  // Extra cutoff halvings beyond the select code, indexed by rate
  localparam logic [KW-1:0] NORMAL_EXTRA [RATES] =
    '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3};
  localparam logic [KW-1:0] LOW_NOISE_EXTRA [RATES] =
    '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8};
  localparam logic [KW-1:0] LOW_POWER_EXTRA [RATES] =
    '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9};
  // log2(rate / (2*pi*16 Hz)) plus K_BIAS
  localparam logic [4:0] RATE_BASE [RATES] =
    '{5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h03, 5'h02, 5'h00};
  localparam logic [4:0]    K_BIAS = 5'h06;
  localparam logic [KW-1:0] K_MIN  = 4'h1;
  localparam logic [KW-1:0] K_RST  = 4'h3;

  localparam wide_t AX_MAX = 17'sh0_1fff;
  localparam wide_t AX_MIN = -17'sh0_2000;

  function automatic axis_t sat_axis(input wide_t v);
    if (v > AX_MAX) return axis_t'(AX_MAX);
    if (v < AX_MIN) return axis_t'(AX_MIN);
    return axis_t'(v);
  endfunction

endpackage

// ---- hpf_axis.sv ----
`timescale 1ns/1ns
module hpf_axis (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  // Control
  input  wire logic              clear_i,
  input  wire logic [3:0]        coeff_k_i,
  // Sample in and out
  input  wire logic              in_vld_i,
  input  accel_cfg_pkg::axis_t   x_i,
  output accel_cfg_pkg::axis_t   y_o
);
  import accel_cfg_pkg::*;

  axis_t x_prev_q, x_prev_d;
  axis_t y_q, y_d;
  logic  primed_q, primed_d;
  wide_t acc;

  // y = (1 - 2^-k) * (y_prev + x - x_prev)
  always_comb begin
    x_prev_d = x_prev_q;
    y_d      = y_q;
    primed_d = primed_q;
    acc      = wide_t'(y_q) + wide_t'(x_i) - wide_t'(x_prev_q);
    if (clear_i) begin
      primed_d = 1'b0;
    end else if (in_vld_i) begin
      x_prev_d = x_i;
      primed_d = 1'b1;
      // First sample after a clear seeds history to avoid a step
      y_d = primed_q ? sat_axis(acc - (acc >>> coeff_k_i)) : '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      x_prev_q <= '0;
      y_q      <= '0;
      primed_q <= 1'b0;
    end else begin
      x_prev_q <= x_prev_d;
      y_q      <= y_d;
      primed_q <= primed_d;
    end
  end

  assign y_o = y_q;

endmodule // hpf_axis

// ---- hpf_coeff_calc.sv ----
`timescale 1ns/1ns
module hpf_coeff_calc (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               nrst_i,
  // Operating point
  input  accel_cfg_pkg::rate_t    rate_i,
  input  accel_cfg_pkg::os_mode_t mode_i,
  input  wire logic [1:0]         sel_i,
  // Results
  output logic [3:0]              cutoff_shift_o,
  output logic [3:0]              coeff_k_o,
  output logic                    update_o
);
  import accel_cfg_pkg::*;

  logic [KW-1:0] shift_q, shift_d, k_q, k_d;
  logic          upd_q, upd_d;
  logic [4:0]    ksum;

  function automatic logic [KW-1:0] extra_shift(input rate_t r,
                                                input os_mode_t m);
    case (m)
      OS_NORMAL:                return NORMAL_EXTRA[r];
      LOW_POWER_LOW_NOISE_MODE: return LOW_NOISE_EXTRA[r];
      OS_LOW_POWER:             return LOW_POWER_EXTRA[r];
      default:                  return '0;
    endcase
  endfunction

  // Cutoff is 16 Hz / 2^shift; always tracks rate, mode and select
  always_comb begin
    shift_d = KW'(sel_i) + extra_shift(rate_i, mode_i);
    ksum    = 5'(shift_d) + RATE_BASE[rate_i] - K_BIAS;
    if (shift_d + RATE_BASE[rate_i] <= 5'(K_BIAS) + 5'(K_MIN)) begin
      k_d = K_MIN;
    end else begin
      k_d = ksum[KW-1:0];
    end
    upd_d = (k_d != k_q) || (shift_d != shift_q);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_q <= '0;
      k_q     <= K_RST;
      upd_q   <= 1'b0;
    end else begin
      shift_q <= shift_d;
      k_q     <= k_d;
      upd_q   <= upd_d;
    end
  end

  assign cutoff_shift_o = shift_q;
  assign coeff_k_o      = k_q;
  assign update_o       = upd_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_rate800_halving;
    $past(rate_i) == RATE_800 |-> shift_q == KW'($past(sel_i));
  endproperty
  a_rate800_halving: assert property (p_rate800_halving)
    else $error("cutoff at top rate not set by select alone");

  property p_high_res_flat;
    $past(mode_i) == OS_HIGH_RES |-> shift_q == KW'($past(sel_i));
  endproperty
  a_high_res_flat: assert property (p_high_res_flat)
    else $error("high resolution cutoff depends on rate");

  property p_low_power_slowest;
    $past(mode_i) == OS_LOW_POWER && $past(rate_i) == RATE_1P56
      && $past(sel_i) == 2'h0 |-> shift_q == 4'h9;
  endproperty
  a_low_power_slowest: assert property (p_low_power_slowest)
    else $error("low power slowest cutoff wrong");

  property p_recompute;
    $changed(sel_i) |=> update_o && shift_q != $past(shift_q);
  endproperty
  a_recompute: assert property (p_recompute)
    else $error("select change did not update coefficient");

endmodule // hpf_coeff_calc

// ---- accel_range_hpf_config.sv ----
`timescale 1ns/1ns
// Behaviour
// - Output samples go out raw or high-pass filtered as software picks.
// - Bit 4 of the data config register picks filtered (1) or raw (0).
// - Bits 1:0 pick range 2 g, 4 g or 8 g; code 11 is reserved.
// - Output scaling is 0.244, 0.488 or 0.976 mg per LSB by range.
// - Cutoff register bit 5 set bypasses the high-pass for pulse data.
// - Cutoff register bit 4 set enables the pulse path low-pass.
// - Cutoff register bits 1:0 pick one of four cutoffs, reset 00.
// - At 800 Hz the cutoff is 16, 8, 4, 2 Hz, halving per code.
// - Cutoff varies with rate and mode, flat in high resolution.
module accel_range_hpf_config (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       nrst_i,
  // Register port from the serial interface
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  output logic [7:0]                      reg_rdata_o,
  // Operating point from the system control logic
  input  accel_cfg_pkg::rate_t            output_sample_rate_i,
  input  accel_cfg_pkg::os_mode_t         oversample_mode_i,
  // Raw samples, 0.244 mg per LSB
  input  wire logic                       sample_valid_i,
  input  accel_cfg_pkg::raw_sample_t      raw_sample_i,
  // Output data path
  output logic                            out_valid_o,
  output accel_cfg_pkg::sample_t          out_sample_o,
  // Pulse detection feed
  output logic                            pulse_valid_o,
  output accel_cfg_pkg::sample_t          pulse_sample_o,
  // Status
  output logic [9:0]                      sensitivity_ug_o,
  output logic [3:0]                      cutoff_shift_o
);
  import accel_cfg_pkg::*;

  data_cfg_t     data_cfg_q, data_cfg_d;
  cut_cfg_t      cut_cfg_q, cut_cfg_d;
  logic [7:0]    rdata_q, rdata_d;
  logic [9:0]    sens_q, sens_d;

  logic          scale_vld_q, scale_vld_d;
  sample_t       scaled_q, scaled_d;
  logic          hpf_vld_q, hpf_vld_d;
  logic          out_vld_q, out_vld_d;
  sample_t       out_q, out_d;
  logic          pls_vld_q, pls_vld_d;
  sample_t       pls_q, pls_d;
  sample_t       lpf_prev_q, lpf_prev_d;
  sample_t       hpf_y;
  sample_t       pre;
  logic [KW-1:0] coeff_k;
  logic          coeff_upd;

  function automatic axis_t scale_axis(input raw_t r, input range_t s);
    case (s)
      RANGE_2G: return sat_axis(wide_t'(r));
      RANGE_4G: return sat_axis(wide_t'(r >>> SHIFT_4G));
      // Reserved code falls back to the widest range
      default:  return sat_axis(wide_t'(r >>> SHIFT_8G));
    endcase
  endfunction

  function automatic axis_t avg_axis(input axis_t a, input axis_t b);
    logic signed [AXW:0] sum;
    sum = (AXW+1)'(a) + (AXW+1)'(b);
    return sum[AXW:1];
  endfunction

  // Configuration registers
  always_comb begin
    data_cfg_d = data_cfg_q;
    cut_cfg_d  = cut_cfg_q;
    rdata_d    = rdata_q;
    if (reg_wr_i && reg_addr_i == ADDR_DATA_CFG) begin
      data_cfg_d.hpf_out      = reg_wdata_i[HPF_OUT_BIT];
      data_cfg_d.range_select =
        range_t'(reg_wdata_i[RANGE_LSB +: RANGE_W]);
    end
    if (reg_wr_i && reg_addr_i == ADDR_HPF_CUT) begin
      cut_cfg_d.pulse_hpf_byp = reg_wdata_i[PULSE_BYP_BIT];
      cut_cfg_d.pulse_lpf_en  = reg_wdata_i[PULSE_LPF_BIT];
      cut_cfg_d.cutoff_sel    = reg_wdata_i[SEL_LSB +: SEL_W];
    end
    if (reg_rd_i) begin
      rdata_d = '0;
      case (reg_addr_i)
        ADDR_DATA_CFG: begin
          rdata_d[HPF_OUT_BIT]            = data_cfg_q.hpf_out;
          rdata_d[RANGE_LSB +: RANGE_W]   = data_cfg_q.range_select;
        end
        ADDR_HPF_CUT: begin
          rdata_d[PULSE_BYP_BIT]          = cut_cfg_q.pulse_hpf_byp;
          rdata_d[PULSE_LPF_BIT]          = cut_cfg_q.pulse_lpf_en;
          rdata_d[SEL_LSB +: SEL_W]       = cut_cfg_q.cutoff_sel;
        end
        default: rdata_d = '0;
      endcase
    end
    case (data_cfg_d.range_select)
      RANGE_2G: sens_d = SENS_2G_UG;
      RANGE_4G: sens_d = SENS_4G_UG;
      default:  sens_d = SENS_8G_UG;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_cfg_q <= DATA_CFG_RST;
      cut_cfg_q  <= HPF_CUT_RST;
      rdata_q    <= '0;
      sens_q     <= SENS_2G_UG;
    end else begin
      data_cfg_q <= data_cfg_d;
      cut_cfg_q  <= cut_cfg_d;
      rdata_q    <= rdata_d;
      sens_q     <= sens_d;
    end
  end

  // Coefficient tracking; a change clears filter history
  hpf_coeff_calc u_coeff (
    .core_clk_i     (core_clk_i),
    .nrst_i         (nrst_i),
    .rate_i         (output_sample_rate_i),
    .mode_i         (oversample_mode_i),
    .sel_i          (cut_cfg_q.cutoff_sel),
    .cutoff_shift_o (cutoff_shift_o),
    .coeff_k_o      (coeff_k),
    .update_o       (coeff_upd)
  );

  // The filter always runs so that switching the output over to it
  // shows a settled value rather than a start-up transient.
  for (genvar i = 0; i < NAX; i++) begin : g_hpf
    hpf_axis u_hpf (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .clear_i    (coeff_upd),
      .coeff_k_i  (coeff_k),
      .in_vld_i   (scale_vld_q),
      .x_i        (scaled_q.ax[i]),
      .y_o        (hpf_y.ax[i])
    );
  end

  // Sample path: scale, filter, route
  always_comb begin
    scale_vld_d = sample_valid_i;
    scaled_d    = scaled_q;
    hpf_vld_d   = scale_vld_q;
    out_vld_d   = hpf_vld_q;
    out_d       = out_q;
    pls_vld_d   = hpf_vld_q;
    pls_d       = pls_q;
    lpf_prev_d  = lpf_prev_q;
    pre         = cut_cfg_q.pulse_hpf_byp ? scaled_q : hpf_y;
    if (sample_valid_i) begin
      for (int i = 0; i < NAX; i++) begin
        scaled_d.ax[i] = scale_axis(raw_sample_i.ax[i],
                                    data_cfg_q.range_select);
      end
    end
    if (hpf_vld_q) begin
      out_d      = data_cfg_q.hpf_out ? hpf_y : scaled_q;
      lpf_prev_d = pre;
      for (int i = 0; i < NAX; i++) begin
        pls_d.ax[i] = cut_cfg_q.pulse_lpf_en ?
          avg_axis(pre.ax[i], lpf_prev_q.ax[i]) : pre.ax[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scale_vld_q <= 1'b0;
      scaled_q    <= '0;
      hpf_vld_q   <= 1'b0;
      out_vld_q   <= 1'b0;
      out_q       <= '0;
      pls_vld_q   <= 1'b0;
      pls_q       <= '0;
      lpf_prev_q  <= '0;
    end else begin
      scale_vld_q <= scale_vld_d;
      scaled_q    <= scaled_d;
      hpf_vld_q   <= hpf_vld_d;
      out_vld_q   <= out_vld_d;
      out_q       <= out_d;
      pls_vld_q   <= pls_vld_d;
      pls_q       <= pls_d;
      lpf_prev_q  <= lpf_prev_d;
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign sensitivity_ug_o = sens_q;
  assign out_valid_o      = out_vld_q;
  assign out_sample_o     = out_q;
  assign pulse_valid_o    = pls_vld_q;
  assign pulse_sample_o   = pls_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_out_route;
    out_valid_o |-> out_sample_o == ($past(data_cfg_q.hpf_out) ?
                                     $past(hpf_y) : $past(scaled_q));
  endproperty
  a_out_route: assert property (p_out_route)
    else $error("output not routed per filter select");

  property p_out_latency;
    sample_valid_i |-> ##3 out_valid_o && pulse_valid_o;
  endproperty
  a_out_latency: assert property (p_out_latency)
    else $error("sample did not reach outputs in three cycles");

  property p_hpf_out_write;
    reg_wr_i && reg_addr_i == ADDR_DATA_CFG |=>
      reg_rd_i || data_cfg_q.hpf_out == $past(reg_wdata_i[HPF_OUT_BIT]);
  endproperty
  a_hpf_out_write: assert property (p_hpf_out_write)
    else $error("filter enable bit not stored");

  property p_range_readback;
    reg_rd_i && reg_addr_i == ADDR_DATA_CFG && !reg_wr_i |=>
      reg_rdata_o[RANGE_LSB +: RANGE_W] == $past(data_cfg_q.range_select)
      && reg_rdata_o[7:5] == 3'h0;
  endproperty
  a_range_readback: assert property (p_range_readback)
    else $error("range field readback wrong");

  property p_scale_8g;
    scale_vld_q && $past(data_cfg_q.range_select) == RANGE_8G |->
      scaled_q.ax[0] == axis_t'($past(raw_sample_i.ax[0]) >>> SHIFT_8G);
  endproperty
  a_scale_8g: assert property (p_scale_8g)
    else $error("8 g scaling wrong");

  property p_sens_4g;
    data_cfg_q.range_select == RANGE_4G [*2] |-> sensitivity_ug_o == SENS_4G_UG;
  endproperty
  a_sens_4g: assert property (p_sens_4g)
    else $error("4 g sensitivity wrong");

  property p_pulse_bypass;
    pulse_valid_o && !$past(cut_cfg_q.pulse_lpf_en) |->
      pulse_sample_o == ($past(cut_cfg_q.pulse_hpf_byp) ?
                         $past(scaled_q) : $past(hpf_y));
  endproperty
  a_pulse_bypass: assert property (p_pulse_bypass)
    else $error("pulse high-pass bypass wrong");

  property p_pulse_lpf;
    pulse_valid_o && $past(cut_cfg_q.pulse_lpf_en) |->
      pulse_sample_o.ax[0] ==
        avg_axis($past(pre.ax[0]), $past(lpf_prev_q.ax[0]));
  endproperty
  a_pulse_lpf: assert property (p_pulse_lpf)
    else $error("pulse low-pass not applied");

  property p_sel_write;
    reg_wr_i && reg_addr_i == ADDR_HPF_CUT |=>
      cut_cfg_q.cutoff_sel == $past(reg_wdata_i[SEL_LSB +: SEL_W]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("cutoff select not stored");

  property p_cut_readback;
    reg_rd_i && reg_addr_i == ADDR_HPF_CUT && !reg_wr_i |=>
      reg_rdata_o[SEL_LSB +: SEL_W] == $past(cut_cfg_q.cutoff_sel)
      && reg_rdata_o[PULSE_BYP_BIT] == $past(cut_cfg_q.pulse_hpf_byp)
      && reg_rdata_o[PULSE_LPF_BIT] == $past(cut_cfg_q.pulse_lpf_en);
  endproperty
  a_cut_readback: assert property (p_cut_readback)
    else $error("cutoff register readback wrong");

  property p_pulse_cfg_write;
    reg_wr_i && reg_addr_i == ADDR_HPF_CUT |=>
      cut_cfg_q.pulse_hpf_byp == $past(reg_wdata_i[PULSE_BYP_BIT])
      && cut_cfg_q.pulse_lpf_en == $past(reg_wdata_i[PULSE_LPF_BIT]);
  endproperty
  a_pulse_cfg_write: assert property (p_pulse_cfg_write)
    else $error("pulse path controls not stored");

  property p_range_write;
    reg_wr_i && reg_addr_i == ADDR_DATA_CFG |=>
      data_cfg_q.range_select == $past(reg_wdata_i[RANGE_LSB +: RANGE_W]);
  endproperty
  a_range_write: assert property (p_range_write)
    else $error("range field not stored");

  // Sensitivity trails the range by nothing; two cycles skip the write edge
  property p_sens_8g;
    data_cfg_q.range_select == RANGE_8G [*2] |->
      sensitivity_ug_o == SENS_8G_UG;
  endproperty
  a_sens_8g: assert property (p_sens_8g)
    else $error("8 g sensitivity wrong");

  c_hpf_out:   cover property (out_valid_o && data_cfg_q.hpf_out);
  c_pulse_lpf: cover property (pulse_valid_o && cut_cfg_q.pulse_lpf_en);
  c_range_8g:  cover property (scale_vld_q &&
                               data_cfg_q.range_select == RANGE_8G);
  c_coeff:     cover property (coeff_upd ##[1:20] out_valid_o);

endmodule // accel_range_hpf_config

// ---- host_model.sv ----
`timescale 1ns/1ns
module host_model (
  // Clock
  input  wire logic       core_clk_i,
  // Register port toward the device
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  import accel_cfg_pkg::*;

  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One-cycle strobe; idle lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_DATA_CFG && v[1:0] == 2'b11) v[1:0] = 2'b10;
    @(negedge core_clk_i);
    reg_addr_o  = a;
    reg_wdata_o = v;
    reg_wr_o    = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~v;
  endtask

  // Data is taken two edges on, valid under either read latency
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    @(negedge core_clk_i);
    d = reg_rdata_i;
  endtask
endmodule // host_model

// ---- accel_range_hpf_config_tb_top.sv ----
`timescale 1ns/1ns
module accel_range_hpf_config_tb_top;
  import accel_cfg_pkg::*;
  typedef struct { sample_t o; sample_t p; int cyc; } note_t;
  // Extra cutoff halvings per mode, one nibble per rate code
  localparam logic [31:0] XTRA [4] =
    '{32'h3333_2100, 32'h8653_2100, 32'h0000_0000, 32'h9764_3210};

  logic        core_clk_i = 1'b0;
  logic        nrst_i     = 1'b0;
  logic        reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  rate_t       rate       = RATE_800;
  os_mode_t    mode       = OS_NORMAL;
  logic        sample_valid_i = 1'b0;
  raw_sample_t raw_sample_i   = '0;
  logic        out_valid_o, pulse_valid_o;
  sample_t     out_sample_o, pulse_sample_o;
  logic [9:0]  sensitivity_ug_o;
  logic [3:0]  cutoff_shift_o;
  int          n_errors, samples_checked, cyc;
  note_t       notes[$];
  sample_t     prev_pre;

  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;

  host_model u_host (.core_clk_i(core_clk_i), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata));

  accel_range_hpf_config uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .output_sample_rate_i(rate), .oversample_mode_i(mode),
    .sample_valid_i(sample_valid_i), .raw_sample_i(raw_sample_i),
    .out_valid_o(out_valid_o), .out_sample_o(out_sample_o),
    .pulse_valid_o(pulse_valid_o), .pulse_sample_o(pulse_sample_o),
    .sensitivity_ug_o(sensitivity_ug_o), .cutoff_shift_o(cutoff_shift_o));

  function automatic axis_t scale(input raw_t r, input logic [1:0] rs);
    raw_t s;
    s = (rs == 2'b00) ? r : (rs == 2'b01) ? (r >>> 1) : (r >>> 2);
    if (s > 16'sh1fff) return axis_t'(16'sh1fff);
    if (s < -16'sh2000) return axis_t'(-16'sh2000);
    return axis_t'(s);
  endfunction

  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: register read %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_stat(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: status %0d expected %0d", $time, g, e);
    end
  endtask

  task automatic cmp_smp(input sample_t g, input sample_t e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: sample %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    cmp_reg(d, e);
  endtask

  // Filtered route is only used with steady input, where it must give zero
  task automatic send(input raw_sample_t r, input logic [1:0] rs,
                      input bit hpf, input bit lpf, input bit byp);
    note_t   n;
    sample_t sc, pre;
    for (int i = 0; i < NAX; i++) sc.ax[i] = scale(r.ax[i], rs);
    n.o = hpf ? '0 : sc;
    pre = byp ? sc : '0;
    for (int i = 0; i < NAX; i++)
      n.p.ax[i] = lpf ? axis_t'((wide_t'(pre.ax[i])
                  + wide_t'(prev_pre.ax[i])) >>> 1) : pre.ax[i];
    prev_pre = pre;
    @(negedge core_clk_i);
    raw_sample_i   = r;
    sample_valid_i = 1'b1;
    n.cyc = cyc;
    notes.push_back(n);
    @(negedge core_clk_i);
    sample_valid_i = 1'b0;
    raw_sample_i   = ~r;
    repeat (2) @(negedge core_clk_i);
  endtask

  always @(negedge core_clk_i) begin
    note_t n;
    if (out_valid_o === 1'b1) begin
      if (notes.size() == 0) begin
        n_errors++;
        $display("Error at %0t: output with no sample sent", $time);
      end else begin
        n = notes.pop_front();
        cmp_stat(16'(cyc), 16'(n.cyc + 3));
        cmp_smp(out_sample_o, n.o);
        cmp_stat(16'(pulse_valid_o), 16'd1);
        cmp_smp(pulse_sample_o, n.p);
      end
    end else if (pulse_valid_o !== 1'b0) begin
      n_errors++;
      $display("Error at %0t: pulse valid without output valid", $time);
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic [7:0]  d;
    raw_sample_t r;
    n_errors        = 0;
    samples_checked = 0;
    prev_pre        = '0;
    void'($urandom(7));
    repeat (20) @(negedge core_clk_i);
    nrst_i = 1'b1;
    check_reg(ADDR_DATA_CFG, 8'h00);
    check_reg(ADDR_HPF_CUT, 8'h00);
    check_reg(8'h10, 8'h00);
    cmp_stat(16'(sensitivity_ug_o), 16'd244);
    $display("Test reset values done");
    for (int rs = 0; rs < 3; rs++) begin
      d = 8'($urandom);
      d[1:0] = 2'(rs);
      u_host.wr(ADDR_DATA_CFG, d);
      u_host.wr(8'h10, ~d);
      check_reg(ADDR_DATA_CFG, d & 8'h13);
      cmp_stat(16'(sensitivity_ug_o), 16'd244 << rs);
      d = 8'($urandom);
      u_host.wr(ADDR_HPF_CUT, d);
      check_reg(ADDR_HPF_CUT, d & 8'h33);
    end
    $display("Test register access done");
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 8; k++)
        for (int s = 0; s < 4; s++) begin
          @(negedge core_clk_i);
          mode = os_mode_t'(m);
          rate = rate_t'(k);
          u_host.wr(ADDR_HPF_CUT, 8'(s));
          repeat (2) @(negedge core_clk_i);
          cmp_stat(16'(cutoff_shift_o), 16'(s + XTRA[m][4*k +: 4]));
        end
    $display("Test cutoff table done");
    @(negedge core_clk_i);
    mode = OS_NORMAL;
    rate = RATE_800;
    for (int lpf = 0; lpf < 2; lpf++)
      for (int rs = 0; rs < 3; rs++) begin
        u_host.wr(ADDR_DATA_CFG, 8'(rs));
        u_host.wr(ADDR_HPF_CUT, 8'h20 | 8'(lpf << 4));
        for (int j = 0; j < 6; j++) begin
          for (int i = 0; i < NAX; i++)
            r.ax[i] = (j == 0) ? 16'sh7fff : (j == 1) ? -16'sh8000
                      : raw_t'($urandom);
          send(r, 2'(rs), 1'b0, lpf[0], 1'b1);
        end
      end
    $display("Test direct route done");
    // A new select code clears the filter history before the steady run
    u_host.wr(ADDR_HPF_CUT, 8'h03);
    u_host.wr(ADDR_DATA_CFG, 8'h11);
    repeat (4) @(negedge core_clk_i);
    for (int i = 0; i < NAX; i++) r.ax[i] = raw_t'($urandom) | 16'sh0100;
    repeat (5) send(r, 2'b01, 1'b1, 1'b0, 1'b0);
    repeat (10) @(negedge core_clk_i);
    cmp_stat(16'(notes.size()), 16'd0);
    $display("Test filtered route done");
    end_of_test();
  end
endmodule // accel_range_hpf_config_tb_top
